// File: hdl/cchc_pkg.sv
package cchc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 100;
    localparam int COARSE_UNIT_NS         = 1600000;
    localparam int FINE_UNIT_NS           = 100000;
    localparam int COARSE_UNIT_CYCLES     = COARSE_UNIT_NS / CLK_PERIOD_NS;
    localparam int FINE_UNIT_CYCLES       = FINE_UNIT_NS / CLK_PERIOD_NS;
    localparam int DISCHARGE_CYCLE_US     = 100000;
    localparam int DISCHARGE_CYCLE_CYCLES = (DISCHARGE_CYCLE_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W                = 24;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam int              ADDR_W          = 12;
    localparam logic [11:0]     HW_CTL_ADDR     = 12'h800;
    localparam int              SHORT_HI        = 15;
    localparam int              SHORT_LO        = 14;
    localparam int              PAUSE_BIT       = 12;
    localparam int              UNIT_BIT        = 11;
    localparam int              MODE_BIT        = 10;
    localparam int              DBACT_BIT       = 9;
    localparam int              ATTACH_BIT      = 8;
    localparam int              CAP_HI          = 7;
    localparam int              CAP_LO          = 6;
    localparam int              DTH_HI          = 5;
    localparam int              DTH_LO          = 3;
    localparam int              ROLE_BIT        = 2;
    localparam int              STANDALONE_BIT  = 0;
    localparam logic [1:0]      SHORT_RST       = 2'h0;
    localparam logic            PAUSE_RST       = 1'h0;
    localparam logic            UNIT_RST        = 1'h0;
    localparam logic [1:0]      CAP_NONE        = 2'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0]      SHORT_WAIT_CLEAR   = 2'h2;
    localparam logic [1:0]      SHORT_WAIT_OR_TIME = 2'h3;
    localparam logic [1:0]      STRAP_COMPANION    = 2'h0;
    localparam logic [1:0]      STRAP_SA_UFP       = 2'h1;
    localparam logic [1:0]      STRAP_SA_DFP       = 2'h2;
    localparam logic [1:0]      STRAP_COMP_DFP     = 2'h3;
    localparam logic [1:0]      RESP_OKAY          = 2'h0;
    localparam logic [1:0]      RESP_SLVERR        = 2'h2;

    typedef enum logic {DIS_IDLE, DIS_WAIT} cchc_dis_state_t;

endpackage

// File: hdl/cchc_dis_if.sv
`timescale 1ns/1ps
interface cchc_dis_if;
    logic       request;
    logic       short_present;
    logic       gate_enable;
    logic [1:0] mode;
    logic       discharge_start;
    logic       waiting;

    modport ctrl (output request, output short_present, output gate_enable, output mode,
                  input discharge_start, input waiting);
    modport engine (input request, input short_present, input gate_enable, input mode,
                    output discharge_start, output waiting);
endinterface

// File: hdl/cchc_discharge.sv
`timescale 1ns/1ps
module cchc_discharge
    import cchc_pkg::*;
#(
    parameter int CYCLE_CYCLES = DISCHARGE_CYCLE_CYCLES
) (
    input wire logic   aclk,
    input wire logic   aresetn,
    cchc_dis_if.engine dis
);

    // ------------------------------------------------------------
    // short handling sequencer
    // ------------------------------------------------------------
    cchc_dis_state_t    state_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic               start_reg;
    logic               timed_out;

    assign timed_out = (timer_reg == TIMER_W'(CYCLE_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= DIS_IDLE;
            timer_reg <= '0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                DIS_IDLE: begin
                    if (dis.request) begin
                        if (!dis.gate_enable || !dis.mode[1]) begin
                            start_reg <= 1'b1;
                        end else if (!dis.short_present) begin
                            start_reg <= 1'b1;
                        end else begin
                            state_reg <= DIS_WAIT;
                            timer_reg <= '0;
                        end
                    end
                end
                DIS_WAIT: begin
                    if (!dis.short_present || !dis.mode[1] || !dis.gate_enable) begin
                        start_reg <= 1'b1;
                        state_reg <= DIS_IDLE;
                    end else if (dis.mode == SHORT_WAIT_OR_TIME && timed_out) begin
                        start_reg <= 1'b1;
                        state_reg <= DIS_IDLE;
                    end else begin
                        timer_reg <= timer_reg + TIMER_W'(1);
                    end
                end
                default: begin
                    state_reg <= DIS_IDLE;
                end
            endcase
        end
    end

    assign dis.discharge_start = start_reg;
    assign dis.waiting         = (state_reg == DIS_WAIT);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_UNCHECKED_START: assert property (@(posedge aclk) disable iff (!aresetn)
        !dis.waiting && dis.request && !dis.mode[1] |=> dis.discharge_start)
        else $error("unchecked discharge did not start at once");
    AST_HOLD_WHILE_SHORT: assert property (@(posedge aclk) disable iff (!aresetn)
        dis.waiting && dis.short_present && dis.gate_enable && dis.mode == SHORT_WAIT_CLEAR
        |=> !dis.discharge_start && dis.waiting)
        else $error("discharge started while short still present");
    AST_TIMEOUT_START: assert property (@(posedge aclk) disable iff (!aresetn)
        dis.waiting && timed_out && dis.gate_enable && dis.mode == SHORT_WAIT_OR_TIME
        |=> dis.discharge_start && !dis.waiting)
        else $error("discharge did not start at cycle time");
    COV_WAIT_THEN_START: cover property (@(posedge aclk) disable iff (!aresetn)
        dis.waiting ##1 dis.discharge_start);

endmodule

// File: hdl/cchc_ctrl.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cchc_ctrl
    import cchc_pkg::*;
#(
    parameter int   COARSE_CYCLES  = COARSE_UNIT_CYCLES,
    parameter int   DIS_CYCLES     = DISCHARGE_CYCLE_CYCLES,
    parameter logic HAS_CAP_PINS   = 1'b1
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              config_select_pin0,
    input  wire logic              config_select_pin1,
    input  wire logic              charge_capability_pin0,
    input  wire logic              charge_capability_pin1,
    input  wire logic              debouncer_active_flag,
    input  wire logic              sw_debounce_enable,
    input  wire logic              pd_message_detected,
    input  wire logic              partner_attached,
    input  wire logic              cc_orientation,
    input  wire logic              vconn_request,
    input  wire logic              vbus_discharge_request,
    input  wire logic              vbus_short_present,
    output logic                   debouncer_enable,
    output logic                   debouncer_pause,
    output logic                   match_debounce_tick,
    output logic [2:0]             detach_threshold_select,
    output logic                   port_role_dfp,
    output logic                   standalone_mode,
    output logic                   attach_pin,
    output logic                   orientation_pin,
    output logic                   vconn_enable,
    output logic                   vbus_discharge_start
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a[ADDR_W-1:2] == HW_CTL_ADDR[ADDR_W-1:2]);
    endfunction

    function automatic logic strap_dfp(input logic [1:0] sel);
        strap_dfp = (sel == STRAP_SA_DFP) || (sel == STRAP_COMP_DFP);
    endfunction

    function automatic logic strap_standalone(input logic [1:0] sel);
        strap_standalone = (sel == STRAP_SA_DFP) || (sel == STRAP_SA_UFP);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [1:0] strap_sel;
    logic [1:0] cap_pins;

    always_ff @(posedge aclk) begin
        pin_meta_reg <= {charge_capability_pin1, charge_capability_pin0,
                         config_select_pin1, config_select_pin0};
        pin_sync_reg <= pin_meta_reg;
    end

    assign strap_sel = pin_sync_reg[1:0];
    assign cap_pins  = pin_sync_reg[3:2];

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [1:0]  short_reg;
    logic        pause_reg;
    logic        unit_reg;
    logic [2:0]  dth_reg;
    logic        role_reg;
    logic        standalone_reg;
    logic [1:0]  cap_reg;
    logic        dbact_reg;
    logic        attach_reg;
    logic        do_write;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [31:0] read_value;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            short_reg      <= SHORT_RST;
            pause_reg      <= PAUSE_RST;
            unit_reg       <= UNIT_RST;
            dth_reg        <= HAS_CAP_PINS ? {1'b0, cap_pins} : 3'h0;
            role_reg       <= strap_dfp(strap_sel);
            standalone_reg <= strap_standalone(strap_sel);
        end else if (do_write) begin
            if (ws[1]) begin
                short_reg <= wd[SHORT_HI:SHORT_LO];
                pause_reg <= wd[PAUSE_BIT];
                unit_reg  <= wd[UNIT_BIT];
            end
            if (ws[0]) begin
                dth_reg        <= wd[DTH_HI:DTH_LO];
                role_reg       <= wd[ROLE_BIT];
                standalone_reg <= wd[STANDALONE_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_reg    <= CAP_NONE;
            dbact_reg  <= 1'b0;
            attach_reg <= 1'b0;
        end else begin
            cap_reg    <= HAS_CAP_PINS ? cap_pins : CAP_NONE;
            dbact_reg  <= debouncer_active_flag;
            attach_reg <= partner_attached;
        end
    end

    always_comb begin
        read_value                      = 32'h0000_0000;
        read_value[SHORT_HI:SHORT_LO]   = short_reg;
        read_value[PAUSE_BIT]           = pause_reg;
        read_value[UNIT_BIT]            = unit_reg;
        read_value[MODE_BIT]            = standalone_reg;
        read_value[DBACT_BIT]           = dbact_reg;
        read_value[ATTACH_BIT]          = attach_reg;
        read_value[CAP_HI:CAP_LO]       = cap_reg;
        read_value[DTH_HI:DTH_LO]       = dth_reg;
        read_value[ROLE_BIT]            = role_reg;
        read_value[STANDALONE_BIT]      = standalone_reg;
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid && addr_hit(awaddr_reg);
    assign wd       = wdata_reg;
    assign ws       = {wstrb_reg[3:2], wstrb_reg[1], wstrb_reg[0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held_reg   <= 1'b0;
            awaddr_reg    <= '0;
        end else begin
            s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_held_reg && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held_reg   <= 1'b0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
        end else begin
            s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_held_reg && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= addr_hit(s_axi_araddr) ? read_value : 32'h0000_0000;
                s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // match debounce time base
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] tick_cnt_reg;
    logic [TIMER_W-1:0] tick_limit;

    assign tick_limit = unit_reg ? TIMER_W'(FINE_UNIT_CYCLES - 1) : TIMER_W'(COARSE_CYCLES - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg        <= '0;
            match_debounce_tick <= 1'b0;
        end else if (tick_cnt_reg >= tick_limit) begin
            tick_cnt_reg        <= '0;
            match_debounce_tick <= 1'b1;
        end else begin
            tick_cnt_reg        <= tick_cnt_reg + TIMER_W'(1);
            match_debounce_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // standalone and debouncer outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debouncer_enable        <= 1'b0;
            debouncer_pause         <= 1'b0;
            detach_threshold_select <= 3'h0;
            port_role_dfp           <= 1'b0;
            standalone_mode         <= 1'b0;
            attach_pin              <= 1'b0;
            orientation_pin         <= 1'b0;
            vconn_enable            <= 1'b0;
        end else begin
            debouncer_enable        <= standalone_reg || sw_debounce_enable;
            debouncer_pause         <= pause_reg && pd_message_detected;
            detach_threshold_select <= dth_reg;
            port_role_dfp           <= role_reg;
            standalone_mode         <= standalone_reg;
            attach_pin              <= standalone_reg && partner_attached;
            orientation_pin         <= standalone_reg && partner_attached && cc_orientation;
            vconn_enable            <= standalone_reg && partner_attached && vconn_request;
        end
    end

    // ------------------------------------------------------------
    // vbus discharge sequencing
    // ------------------------------------------------------------
    cchc_dis_if dis_bus ();

    assign dis_bus.request       = vbus_discharge_request;
    assign dis_bus.short_present = vbus_short_present;
    assign dis_bus.gate_enable   = standalone_reg && role_reg;
    assign dis_bus.mode          = short_reg;

    cchc_discharge #(
        .CYCLE_CYCLES (DIS_CYCLES)
    ) u_discharge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dis     (dis_bus.engine)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vbus_discharge_start <= 1'b0;
        end else begin
            vbus_discharge_start <= dis_bus.discharge_start;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PAUSE_ON_MSG: assert property (@(posedge aclk) disable iff (!aresetn)
        pause_reg && pd_message_detected |=> debouncer_pause)
        else $error("debouncer not paused on message");
    AST_NO_PAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        !pause_reg |=> !debouncer_pause)
        else $error("debouncer paused with pause bit clear");
    AST_FINE_UNIT: assert property (@(posedge aclk) disable iff (!aresetn)
        match_debounce_tick && $past(unit_reg) && $past(unit_reg, 2) && $past(match_debounce_tick) == 1'b0
        |-> $past(tick_cnt_reg) == TIMER_W'(FINE_UNIT_CYCLES - 1))
        else $error("fine unit tick spacing wrong");
    AST_COARSE_UNIT: assert property (@(posedge aclk) disable iff (!aresetn)
        match_debounce_tick && !$past(unit_reg) && !$past(unit_reg, 2)
        |-> $past(tick_cnt_reg) == TIMER_W'(COARSE_CYCLES - 1))
        else $error("coarse unit tick spacing wrong");
    AST_MODE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr)
        |=> s_axi_rvalid && s_axi_rdata[MODE_BIT] == $past(standalone_reg)
            && s_axi_rdata[ROLE_BIT] == $past(role_reg))
        else $error("mode or role read back wrong");
    AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[13] && !s_axi_rdata[1])
        else $error("reserved bits not zero");
    AST_COMPANION_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
        !standalone_reg |=> !attach_pin && !vconn_enable && !orientation_pin)
        else $error("standalone pins active in companion mode");
    AST_DEBOUNCE_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        standalone_reg |=> debouncer_enable)
        else $error("debouncer not enabled in standalone mode");
    AST_BRESP_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) do_write ##[1:4] s_axi_bvalid);
    COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    COV_PAUSE: cover property (@(posedge aclk) disable iff (!aresetn) debouncer_pause);

endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
import cchc_pkg::*;
localparam int TB_COARSE = 20;
logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, c0, c1, p0 = 0, p1 = 1;
logic dba = 1, pd = 0, att, req = 0, sh = 0, awr, wrd, bv, arr, rv, den, dps, atp, dst;
logic ori = 0, vr = 0, orp, ven, mt, prd, sam;
logic [2:0]  dts;
logic [11:0] awa = 0, ara = 0;
logic [31:0] wd = 0, rd, ew, rw;
logic [1:0]  bs, rs, wb;
int          bad_count = 0, n_compared = 0, n, k;
initial forever #50 aclk = ~aclk;
cchc_ctrl #(.COARSE_CYCLES(TB_COARSE), .DIS_CYCLES(30)) cchc_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rs), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .config_select_pin0(p0), .config_select_pin1(p1), .charge_capability_pin0(c0),
    .charge_capability_pin1(c1), .debouncer_active_flag(dba), .sw_debounce_enable(1'h0),
    .pd_message_detected(pd), .partner_attached(att), .cc_orientation(ori), .vconn_request(vr),
    .vbus_discharge_request(req), .vbus_short_present(sh), .debouncer_enable(den), .debouncer_pause(dps),
    .match_debounce_tick(mt), .detach_threshold_select(dts), .port_role_dfp(prd), .standalone_mode(sam),
    .attach_pin(atp), .orientation_pin(orp), .vconn_enable(ven), .vbus_discharge_start(dst));
task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
        bad_count++;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
endtask
task automatic wr(input logic [11:0] a, input logic [15:0] d);
    awa <= a; wd <= {16'h0, d}; awv <= 1; wv <= 1; br <= 1;
    for (k = 0; k < 50 && bv !== 1'b1; k++) begin
        @(posedge aclk);
        if (awr === 1'b1) awv <= 0;
        if (wrd === 1'b1) wv <= 0;
    end
    if (k == 50) begin bad_count++; stop_test(); end
    wb = bs; br <= 0; @(posedge aclk);
endtask
task automatic rdr(input logic [11:0] a);
    ara <= a; arv <= 1; rr <= 1;
    for (k = 0; k < 50 && rv !== 1'b1; k++) begin
        @(posedge aclk);
        if (arr === 1'b1) arv <= 0;
    end
    if (k == 50) begin bad_count++; stop_test(); end
    ew = rd; rr <= 0; @(posedge aclk);
endtask
function automatic logic [31:0] ex(input logic [15:0] w);
    return {16'h0, w[15:14], 1'b0, w[12:11], w[0], dba, att, c1, c0, w[5:3], w[2], 1'b0, w[0]};
endfunction
task automatic ds(input int clr);
    req <= 1; @(posedge aclk); req <= 0;
    for (n = 0; n < 80 && dst !== 1'b1; n++) begin
        if (n == clr) sh <= 0;
        @(posedge aclk);
    end
    if (n == 80) begin bad_count++; stop_test(); end
endtask
task automatic tk();
    for (n = 0; n < 1100 && mt !== 1'b1; n++) @(posedge aclk);
    if (n == 1100) bad_count++;
    for (n = 1; n < 1100; n++) begin
        @(posedge aclk);
        if (mt === 1'b1) break;
    end
endtask
initial begin
    void'($urandom(86));
    rw = $urandom;
    c0 <= rw[0]; c1 <= rw[1]; att <= rw[2];
    repeat (6) @(posedge aclk);
    aresetn <= 1; @(posedge aclk);
    rdr(HW_CTL_ADDR); ck(ew, ex({10'h0, 1'b0, c1, c0, 3'h5}));
    ck({den, atp}, {1'b1, att});
    $display("reset test done");
    dba <= 0;
    for (n = 0; n < 10; n++) begin
        rdr(HW_CTL_ADDR);
        if (ew[DBACT_BIT] === 1'b0) break;
    end
    ck(n < 10, 1);
    for (int i = 0; i < 6; i++) begin
        rw = $urandom;
        rw[0] = i[0];
        ori <= rw[16]; vr <= rw[17]; att <= rw[18]; wr(HW_CTL_ADDR, rw[15:0]);
        rdr(HW_CTL_ADDR); ck(ew, ex(rw[15:0]));
        ck({prd, sam, dts}, {rw[2], rw[0], rw[5:3]});
        ck({atp, orp, ven, den}, {rw[0] & att, rw[0] & att & ori, rw[0] & att & vr, rw[0]});
    end
    wr(12'h804, 16'hFFFF); ck(wb, RESP_SLVERR);
    rdr(12'h804); ck(rs, RESP_SLVERR);
    ck(ew, 32'h0);
    rdr(HW_CTL_ADDR); ck(ew, ex(rw[15:0]));
    $display("register test done");
    pd <= 1; wr(HW_CTL_ADDR, 16'h1005); repeat (3) @(posedge aclk);
    ck(dps, 1);
    pd <= 0; repeat (3) @(posedge aclk);
    ck(dps, 0);
    pd <= 1; wr(HW_CTL_ADDR, 16'h0005); repeat (3) @(posedge aclk);
    ck(dps, 0);
    $display("pause test done");
    sh <= 1; ds(1000); ck(n <= 3, 1);
    wr(HW_CTL_ADDR, 16'h8005); sh <= 1; ds(40); ck(n >= 40 && n <= 44, 1);
    sh <= 1; wr(HW_CTL_ADDR, 16'hC005); ds(1000); ck(n >= 30 && n <= 34, 1);
    $display("discharge test done");
    wr(HW_CTL_ADDR, 16'h0000); tk(); ck(n, TB_COARSE);
    wr(HW_CTL_ADDR, 16'h0800); tk(); ck(n, FINE_UNIT_CYCLES);
    $display("tick test done");
    for (int s = 0; s < 4; s++) begin
        rw = $urandom;
        c0 <= rw[0]; c1 <= rw[1]; p0 <= s[0]; p1 <= s[1]; aresetn <= 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1; @(posedge aclk);
        rdr(HW_CTL_ADDR); ck(ew, ex({10'h0, 1'b0, c1, c0, s[1], 1'b0, s[0] ^ s[1]}));
    end
    $display("strap test done");
    stop_test();
end
endmodule
